// [src/tdsa_pkg.sv]
package tdsa_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_PERIOD_LO = 8'hDA;
	localparam logic [7:0] IDX_PERIOD_HI = 8'hDB;
	localparam logic [7:0] IDX_SAMPLE_LO = 8'hDC;
	localparam logic [7:0] IDX_SAMPLE_HI = 8'hDD;
	localparam logic [7:0] IDX_COUNT_LO = 8'hE2;
	localparam logic [7:0] IDX_COUNT_HI = 8'hE3;
	localparam logic [7:0] IDX_CTL_FLAGS = 8'hE4;
	localparam logic [7:0] IDX_CHAN0_CTL = 8'hE5;
	localparam logic [7:0] IDX_CHAN1_CTL = 8'hE6;
	localparam logic [7:0] IDX_TICK_RATE = 8'hE7;

	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int FLAG_LSB = 4;
	localparam int DIV_LSB = 2;
	localparam int CTL_MODE_BIT = 2;
	localparam int ACTION_LSB = 3;
	localparam logic [2:0] ACTION_DSM = 3'h7;
	localparam logic [1:0] MODE_SUSPEND = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_MODULO = 2'h2;
	localparam logic [1:0] MODE_UPDOWN = 2'h3;

	// ------------------------------------------------------------
	// Reset values and fixed counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [2:0] DSM_LAST_QUARTER = 3'h3;
	localparam logic [2:0] DSM_LAST_EIGHTH = 3'h7;
	localparam logic [19:0] DSM_FULL_SCALE = 20'h07FFF;

	// ------------------------------------------------------------
	// Wishbone request carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [9:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tdsa_wb_req_t;

endpackage : tdsa_pkg

// [src/tdsa_top.sv]
`timescale 1ns/1ps

module tdsa_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire tdsa_pkg::tdsa_wb_req_t wb_req_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Audio and sample request
	output logic chan1_pin_o,
	output logic sample_req_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic [7:0] cnt_hi_latch;
		logic dir_down;
		logic [3:0] flags;
		logic [1:0] div;
		logic [1:0] mode;
		logic [6:0] presc;
		logic [6:0] tdiv;
		logic [2:0] tick_sel;
		logic [7:0] c0_ctl;
		logic [7:0] c1_ctl;
		logic [15:0] per;
		logic [7:0] per_lo_buf;
		logic [15:0] smp;
		logic [7:0] smp_lo_buf;
		logic [2:0] dsm_cnt;
		logic [15:0] cur;
		logic [15:0] base;
		logic [23:0] acc;
		logic [19:0] i1;
		logic [23:0] i2;
		logic dsm_bit;
		logic pin;
		logic req;
		logic ack;
		logic [7:0] rdat;
	} tdsa_state_t;

	tdsa_state_t st, next_st;

	// Index of the highest set bit, used as the interpolator gain shift
	function automatic logic [3:0] tdsa_msb(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < 16; k++)
		begin
			if (v[k])
				r = 4'(k);
		end
		return r;
	endfunction : tdsa_msb

	// ------------------------------------------------------------
	// Combinational helpers
	// ------------------------------------------------------------
	logic fire, wr, tick, upd, dsm_on, rate8, dsm_stb;
	logic ovf_ev, c0_ev, c1_ev, wrap;
	logic [7:0] idx, wd;
	logic [6:0] tmask;
	logic [2:0] dsm_last;
	logic [15:0] per_ds, x_lin, x_in;
	logic [3:0] gain_shift;
	logic [19:0] fb, i1_new;
	logic signed [23:0] slope;

	// Bus decode: narrow 8-bit registers sit in the low byte lane
	assign fire = wb_req_i.cyc & wb_req_i.stb & ~st.ack;
	assign wr = fire & wb_req_i.we & wb_req_i.sel[0];
	assign idx = wb_req_i.adr[9:2];
	assign wd = wb_req_i.dat[7:0];

	// Tick rate divider: clk divided by 2^tick_sel
	assign tmask = 7'((8'h01 << st.tick_sel) - 8'h01);
	assign tick = ((st.tdiv & tmask) == tmask);

	// Counter update enable from the prescaler
	always_comb
	begin
		upd = 1'b0;
		if (tick)
		begin
			if (dsm_on)
				upd = 1'b1;
			else
				case (st.div)
					2'h0: upd = 1'b1;
					2'h1: upd = (st.presc[2:0] == 3'h7);
					2'h2: upd = (st.presc[4:0] == 5'h1F);
					2'h3: upd = (st.presc == 7'h7F);
					default: upd = 1'b0;
				endcase
		end
	end

	// Modulator enable and rate, live from the channel 1 control
	assign dsm_on = (st.c1_ctl[5:3] == tdsa_pkg::ACTION_DSM);
	assign rate8 = st.c1_ctl[tdsa_pkg::CTL_MODE_BIT];
	assign dsm_last = rate8 ? tdsa_pkg::DSM_LAST_EIGHTH
		: tdsa_pkg::DSM_LAST_QUARTER;
	assign dsm_stb = dsm_on & tick & (st.dsm_cnt == dsm_last);

	// Interpolator gain follows modulator steps per sample period
	assign per_ds = rate8 ? (st.per >> 3) : (st.per >> 2);
	assign gain_shift = tdsa_msb(per_ds);
	assign x_lin = st.base + st.acc[15:0];
	assign x_in = st.c1_ctl[1] ? st.cur : x_lin;
	// Slope kept apart: mixed with unsigned acc the shift would go logical
	assign slope = 24'(signed'({{8{st.cur[15]}}, st.cur}
		- {{8{st.base[15]}}, st.base})) >>> gain_shift;

	// Loop feedback at full scale of the sign of the last bit
	assign fb = st.dsm_bit ? tdsa_pkg::DSM_FULL_SCALE
		: ~tdsa_pkg::DSM_FULL_SCALE;
	assign i1_new = st.i1 + {{4{x_in[15]}}, x_in} - fb;

	// ------------------------------------------------------------
	// Counter step and events
	// ------------------------------------------------------------
	logic [15:0] cnt_step;
	logic dir_step;

	always_comb
	begin
		cnt_step = st.cnt;
		dir_step = st.dir_down;
		ovf_ev = 1'b0;
		c0_ev = 1'b0;
		wrap = 1'b0;
		case (st.mode)
			tdsa_pkg::MODE_FREE:
			begin
				cnt_step = st.cnt + 16'h0001;
				ovf_ev = (st.cnt == 16'hFFFF);
				c0_ev = st.c0_ctl[2] & (st.cnt == st.per);
			end
			tdsa_pkg::MODE_MODULO:
			begin
				if (st.cnt >= st.per)
				begin
					cnt_step = tdsa_pkg::RST_WORD;
					ovf_ev = 1'b1;
					wrap = 1'b1;
				end
				else
					cnt_step = st.cnt + 16'h0001;
				c0_ev = st.c0_ctl[2] & (st.cnt == st.per);
			end
			tdsa_pkg::MODE_UPDOWN:
			begin
				if (st.dir_down && st.cnt == 16'h0000)
				begin
					dir_step = 1'b0;
					cnt_step = 16'h0001;
					ovf_ev = 1'b1;
					c0_ev = st.c0_ctl[2];
				end
				else if (!st.dir_down && st.cnt >= st.per)
				begin
					dir_step = 1'b1;
					cnt_step = st.cnt - 16'h0001;
				end
				else if (st.dir_down)
					cnt_step = st.cnt - 16'h0001;
				else
					cnt_step = st.cnt + 16'h0001;
			end
			default:
				cnt_step = st.cnt;
		endcase
	end

	// Channel 1 compare flag only in ordinary compare use
	assign c1_ev = upd & ~dsm_on & st.c1_ctl[2] & (st.mode != 2'h0)
		& (st.cnt == st.smp);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [3:0] keep;
		logic [3:0] ev;
		keep = 4'hF;
		ev = 4'h0;
		next_st = st;

		// Free-running dividers; writes never reset them
		next_st.tdiv = st.tdiv + 7'h01;
		if (tick)
			next_st.presc = st.presc + 7'h01;

		// Counter runs only while mode is not suspended
		if (upd && st.mode != tdsa_pkg::MODE_SUSPEND)
		begin
			next_st.cnt = cnt_step;
			next_st.dir_down = dir_step;
		end

		// Bus handshake: one wait cycle, ack for one cycle
		next_st.ack = fire;
		next_st.req = 1'b0;

		// Register reads, with the high count byte latched
		if (fire && !wb_req_i.we)
		begin
			case (idx)
				tdsa_pkg::IDX_COUNT_LO:
				begin
					next_st.rdat = st.cnt[7:0];
					next_st.cnt_hi_latch = st.cnt[15:8];
				end
				tdsa_pkg::IDX_COUNT_HI:
					next_st.rdat = st.cnt_hi_latch;
				tdsa_pkg::IDX_CTL_FLAGS:
					next_st.rdat = {st.flags, st.div, st.mode};
				tdsa_pkg::IDX_CHAN0_CTL:
					next_st.rdat = st.c0_ctl;
				tdsa_pkg::IDX_CHAN1_CTL:
					next_st.rdat = st.c1_ctl;
				tdsa_pkg::IDX_PERIOD_LO:
					next_st.rdat = st.per[7:0];
				tdsa_pkg::IDX_PERIOD_HI:
					next_st.rdat = st.per[15:8];
				tdsa_pkg::IDX_SAMPLE_LO:
					next_st.rdat = st.smp[7:0];
				tdsa_pkg::IDX_SAMPLE_HI:
					next_st.rdat = st.smp[15:8];
				tdsa_pkg::IDX_TICK_RATE:
					next_st.rdat = {5'h00, st.tick_sel};
				default:
					next_st.rdat = tdsa_pkg::RST_BYTE;
			endcase
		end
		else if (fire)
			next_st.rdat = tdsa_pkg::RST_BYTE;

		// Register writes
		if (wr)
		begin
			case (idx)
				tdsa_pkg::IDX_COUNT_LO:
				begin
					next_st.cnt = tdsa_pkg::RST_WORD;
					next_st.dir_down = 1'b0;
				end
				tdsa_pkg::IDX_CTL_FLAGS:
				begin
					keep = wd[7:4];
					next_st.div = wd[3:2];
					next_st.mode = wd[1:0];
				end
				tdsa_pkg::IDX_CHAN0_CTL:
					next_st.c0_ctl = wd;
				tdsa_pkg::IDX_CHAN1_CTL:
					next_st.c1_ctl = wd;
				tdsa_pkg::IDX_PERIOD_LO:
					next_st.per_lo_buf = wd;
				tdsa_pkg::IDX_PERIOD_HI:
					next_st.per = {wd, st.per_lo_buf};
				tdsa_pkg::IDX_SAMPLE_LO:
					next_st.smp_lo_buf = wd;
				tdsa_pkg::IDX_SAMPLE_HI:
					next_st.smp = {wd, st.smp_lo_buf};
				tdsa_pkg::IDX_TICK_RATE:
					next_st.tick_sel = wd[2:0];
				default:
					next_st.tick_sel = st.tick_sel;
			endcase
		end

		// Pending flags: an event in the clearing cycle wins
		if (upd && st.mode != tdsa_pkg::MODE_SUSPEND)
			ev = {1'b0, 1'b0, c0_ev, ovf_ev};
		ev[2] = c1_ev;
		next_st.flags = (st.flags & keep) | ev;

		// Modulator: idle and cleared while disabled
		if (!dsm_on)
		begin
			next_st.dsm_cnt = 3'h0;
			next_st.i1 = 20'h00000;
			next_st.i2 = 24'h000000;
			next_st.dsm_bit = 1'b0;
			next_st.acc = 24'h000000;
		end
		else
		begin
			if (tick)
				next_st.dsm_cnt = (st.dsm_cnt == dsm_last) ? 3'h0
					: st.dsm_cnt + 3'h1;
			if (dsm_stb)
			begin
				// Two integrators, one-bit quantiser
				next_st.i1 = i1_new;
				next_st.i2 = st.i2 + {{4{i1_new[19]}}, i1_new}
					- {{4{fb[19]}}, fb};
				next_st.dsm_bit = ~next_st.i2[23];
				next_st.acc = st.acc + slope;
			end
		end

		// New sample taken at each counter wrap in modulo mode
		if (dsm_on && upd && wrap)
		begin
			next_st.base = x_in;
			next_st.cur = {st.smp[15:2], 2'b00};
			next_st.acc = 24'h000000;
			next_st.req = 1'b1;
		end

		// Pin: shaped or plain modulator bit, idle low otherwise
		if (!dsm_on)
			next_st.pin = 1'b0;
		else if (st.c1_ctl[0])
			next_st.pin = st.dsm_bit ? (st.dsm_cnt != dsm_last)
				: (st.dsm_cnt == 3'h0);
		else
			next_st.pin = st.dsm_bit;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs straight from state flops
	assign wb_ack_o = st.ack;
	assign wb_dat_o = {24'h000000, st.rdat};
	assign chan1_pin_o = st.pin;
	assign sample_req_o = st.req;

endmodule : tdsa_top

// [bench/tdsa_chk.sv]
`timescale 1ns/1ps
module tdsa_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire tdsa_pkg::tdsa_wb_req_t wb_req_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic chan1_pin_o,
	input wire logic sample_req_o
);
	logic on;
	logic rd;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Modulator enable as last written; taken at the request edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			on <= 1'b0;
		else if (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o &&
			wb_req_i.sel[0] && wb_req_i.adr[9:2] == tdsa_pkg::IDX_CHAN1_CTL)
			on <= wb_req_i.dat[5:3] == tdsa_pkg::ACTION_DSM;
	end
	assign rd = wb_ack_o && !wb_req_i.we;
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_time_a: assert property (
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_cause_a: assert property (
		wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	hi_zero_a: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	flag_two_a: assert property (
		rd && wb_req_i.adr[9:2] == tdsa_pkg::IDX_CTL_FLAGS |-> !wb_dat_o[7])
		else $error("channel 2 flag set");
	pin_off_a: assert property (!on [*4] |-> !chan1_pin_o)
		else $error("pin active with modulator off");
	req_on_a: assert property (
		sample_req_o |-> on || $past(on) || $past(on, 2))
		else $error("sample request with modulator off");
	rst_out_a: assert property (disable iff (1'b0)
		rst_i |=> !wb_ack_o && !sample_req_o && !chan1_pin_o)
		else $error("outputs active after reset");
endmodule : tdsa_chk

bind tdsa_top tdsa_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.chan1_pin_o(chan1_pin_o), .sample_req_o(sample_req_o));

// [bench/tdsa_host.sv]
`timescale 1ns/1ps
module tdsa_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Trigger in, sample out
	input wire logic sample_req_i,
	input wire logic taken_i,
	output logic due_o,
	output logic [15:0] sample_o
);
	// One new sample per trigger; low bits nonzero to show they are dropped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			due_o <= 1'b0;
			sample_o <= 16'h8000;
		end
		else if (sample_req_i)
			due_o <= 1'b1;
		else if (taken_i)
		begin
			due_o <= 1'b0;
			sample_o <= sample_o + 16'h1003;
		end
	end
endmodule : tdsa_host

// [bench/test_tdsa_top.sv]
`timescale 1ns/1ps
module test_tdsa_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic taken = 1'b0;
	logic mon = 1'b0;
	logic last = 1'b0;
	tdsa_pkg::tdsa_wb_req_t req = '0;
	logic wb_ack_o, chan1_pin_o, sample_req_o, due;
	logic [31:0] wb_dat_o;
	logic [15:0] smp;
	logic [7:0] q, h1;
	int bad_count = 0, check_count = 0, cycles = 0, n;
	int reqs = 0, highs = 0, run = 0, maxrun = 0;
	tdsa_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.chan1_pin_o(chan1_pin_o), .sample_req_o(sample_req_o));
	tdsa_host host_u (.clk_i(clk_i), .rst_i(rst_i),
		.sample_req_i(sample_req_o), .taken_i(taken), .due_o(due),
		.sample_o(smp));
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask : chk
	// Holds the request until ack is sampled; no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, w, {a, 2'b00}, 4'h1, {24'h0, d}};
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		req <= '0;
	endtask : bus
	task automatic wr(input logic [7:0] a, d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [7:0] a, e, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, q, e);
	endtask : rc
	// Modulator monitor and hang limit
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (mon)
		begin
			reqs += sample_req_o;
			highs += chan1_pin_o;
			run = (chan1_pin_o === last) ? run + 1 : 1;
			last = chan1_pin_o;
			if (run > maxrun)
				maxrun = run;
		end
		if (cycles == 20000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'hE2, 8'h00, "cnt_lo");
		rc(8'hE3, 8'h00, "cnt_hi");
		rc(8'hE4, 8'h00, "ctl");
		$display("test reset done");
		wr(8'hDA, 8'h03);
		wr(8'hDB, 8'h00);
		wr(8'hE4, 8'h02);
		repeat (20) @(posedge clk_i);
		rc(8'hE4, 8'h12, "ovf");
		wr(8'hE4, 8'h10);
		rc(8'hE4, 8'h10, "keep");
		wr(8'hE4, 8'h00);
		rc(8'hE4, 8'h00, "clr");
		wr(8'hE2, 8'h5A);
		wr(8'hE4, 8'h0D);
		repeat (200) @(posedge clk_i);
		bus(1'b0, 8'hE2, 8'h00);
		chk("div", q inside {[1:3]}, 1);
		$display("test flags done");
		wr(8'hE4, 8'h01);
		wr(8'hE2, 8'h00);
		repeat (600) @(posedge clk_i);
		bus(1'b0, 8'hE2, 8'h00);
		bus(1'b0, 8'hE3, 8'h00);
		h1 = q;
		repeat (300) @(posedge clk_i);
		rc(8'hE3, h1, "latch");
		chk("free", h1 > 1, 1);
		wr(8'hE4, 8'h00);
		wr(8'hE2, 8'h00);
		rc(8'hE2, 8'h00, "clr_lo");
		rc(8'hE3, 8'h00, "clr_hi");
		$display("test count done");
		wr(8'hDA, 8'h0F);
		rc(8'hDA, 8'h03, "per_buf");
		wr(8'hDB, 8'h00);
		rc(8'hDA, 8'h0F, "per_lo");
		wr(8'hE5, 8'h04);
		wr(8'hDC, 8'h00);
		wr(8'hDD, 8'h00);
		wr(8'hE4, 8'h0E);
		wr(8'hE6, 8'h3D);
		mon = 1'b1;
		n = cycles + 1600;
		while (cycles < n)
			if (due)
			begin
				wr(8'hDC, smp[7:0]);
				wr(8'hDD, smp[15:8]);
				taken <= 1'b1;
				@(posedge clk_i);
				taken <= 1'b0;
				@(posedge clk_i);
			end
			else
				@(posedge clk_i);
		mon = 1'b0;
		chk("reqs", reqs inside {[99:101]}, 1);
		chk("run", maxrun < 9, 1);
		chk("duty", highs inside {[1:1599]}, 1);
		wr(8'hE6, 8'h00);
		repeat (4) @(posedge clk_i);
		chk("pin", chan1_pin_o, 0);
		$display("test dsm done");
		end_of_test();
	end
endmodule : test_tdsa_top
